/* design/fuse_config_loader_params.svh */
// offsets, field positions, factory values and timing counts of the fuse loader
`ifndef FUSE_CONFIG_LOADER_PARAMS_SVH
`define FUSE_CONFIG_LOADER_PARAMS_SVH

`define FUSE_ADDR_W 4
`define FUSE_COUNT 9
`define FUSE_OFS_WATCHDOG 4'h0
`define FUSE_OFS_BROWNOUT 4'h1
`define FUSE_OFS_OSCILLATOR 4'h2
`define FUSE_OFS_RSVD_LO 4'h3
`define FUSE_OFS_RSVD_HI 4'h4
`define FUSE_OFS_SYSTEM_CONFIG_FUSE_0 4'h5
`define FUSE_OFS_SYSTEM_CONFIG_FUSE_1 4'h6
`define FUSE_OFS_APP_CODE 4'h7
`define FUSE_OFS_BOOT 4'h8
`define FUSE_FACTORY_ZERO 8'h00
`define FUSE_FACTORY_OSC 8'h00
`define FUSE_OSC_RSVD_MASK 8'hf0
`define FUSE_WDT_WINDOW_MSB 7
`define FUSE_WDT_WINDOW_LSB 4
`define FUSE_WDT_PERIOD_MSB 3
`define FUSE_WDT_PERIOD_LSB 0
`define FUSE_BOD_LEVEL_MSB 7
`define FUSE_BOD_LEVEL_LSB 5
`define FUSE_BOD_SAMP_BIT 4
`define FUSE_BOD_ACT_MSB 3
`define FUSE_BOD_ACT_LSB 2
`define FUSE_BOD_SLP_MSB 1
`define FUSE_BOD_SLP_LSB 0
`define FUSE_OSC_SEL_MSB 3
`define FUSE_OSC_SEL_LSB 0
`define FUSE_BOD_LEVEL_MAX 3'h3
`define FUSE_BOD_MODE_CONT_WAIT 2'h3
`define FUSE_BOD_MODE_RSVD 2'h3
`define FUSE_OSC_SEL_MAX 4'h1
`define FUSE_LOAD_CYCLES 4'h9

`endif

/* design/fuse_config_loader_pkg.sv */
// types shared by the fuse loader modules
package fuse_config_loader_pkg;

	typedef logic [7:0] fuse_byte_t;
	typedef logic [3:0] fuse_addr_t;

	typedef enum logic [1:0] {
		ST_RESET = 2'b00,
		ST_LOAD = 2'b01,
		ST_RUN = 2'b10
	} loader_state_t;

	typedef enum logic [1:0] {
		BOD_DISABLED = 2'b00,
		BOD_CONTINUOUS = 2'b01,
		BOD_SAMPLED = 2'b10,
		BOD_CONT_WAIT = 2'b11
	} bod_mode_t;

	typedef struct packed {
		logic [3:0] window;
		logic [3:0] period;
	} watchdog_ctrl_t;

	typedef struct packed {
		logic sample_rate;
		bod_mode_t active_mode;
		bod_mode_t sleep_mode;
	} bod_ctrl_first_t;

endpackage

/* design/fuse_array_if.sv */
// link between the loader and its fuse storage array
`timescale 1ns/1ps
interface fuse_array_if;
	import fuse_config_loader_pkg::*;
	fuse_addr_t rd_addr;
	fuse_byte_t rd_data;
	logic wr_en;
	fuse_addr_t wr_addr;
	fuse_byte_t wr_data;
	modport loader (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
	modport array (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface

/* design/fuse_array.sv */
// nonvolatile fuse byte storage with factory contents
`timescale 1ns/1ps
`include "fuse_config_loader_params.svh"
module fuse_array #(
	parameter int NUM_FUSES = `FUSE_COUNT
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	fuse_array_if.array port
);
	import fuse_config_loader_pkg::*;

	typedef struct packed {
		fuse_byte_t [NUM_FUSES-1:0] mem;
		logic primed;
	} array_state_t;

	array_state_t state_reg;
	array_state_t state_next;

	// factory content only once at power-up; later resets keep programmed bytes
	always_comb begin
		state_next = state_reg;
		// test for a set flag so that an undefined power-up flag also takes the fill branch
		if (state_reg.primed == 1'b1) begin
			if (port.wr_en && (32'(port.wr_addr) < NUM_FUSES)) begin
				state_next.mem[port.wr_addr] = port.wr_data; // [R1]
			end
		end else begin
			for (int i = 0; i < NUM_FUSES; i++) begin
				state_next.mem[i] = `FUSE_FACTORY_ZERO; // [R12]
			end
			state_next.primed = 1'b1;
		end
	end

	always_ff @(posedge core_clk_in) begin
		state_reg <= state_next;
	end

	assign port.rd_data = (32'(port.rd_addr) < NUM_FUSES) ? state_reg.mem[port.rd_addr] : 8'h00;
endmodule

/* design/fuse_config_loader.sv */
// fuse storage and reset-time copy of configuration fuses into peripheral controls
// How it works
// [R1] cpu and programming port can both read fuses but only the programming port writes them.
// [R2] once start-up completes every configuration fuse has been copied into its target control field; system, code and boot fuses are not copied.
// [R3] a fuse written during operation changes no control output until the next reset reloads it.
// [R4] the programmer writes zero into all reserved bits of a fuse byte.
// [R5] watchdog fuse bits 7:4 load the watchdog window field on reset.
// [R6] watchdog fuse bits 3:0 load the watchdog period field on reset.
// [R7] brown-out fuse bits 7:5 load the threshold field, codes above 0x3 being reserved.
// [R8] brown-out fuse bit 4 loads the sample-rate bit, zero 128 hz and one 32 hz.
// [R9] brown-out fuse bits 3:2 load the active mode field.
// [R10] active mode 0x3 runs continuously and holds execution at wake until the detector runs.
// [R11] brown-out fuse bits 1:0 load the sleep mode field, 0x3 being reserved.
// [R12] watchdog, brown-out and oscillator fuses leave the factory as 0x00.
// [R13] oscillator fuse bits 3:0 pick the default clock source, codes above 0x1 reserved.
// [R14] cpu reads have no side effect and cpu writes never change a fuse.
`timescale 1ns/1ps
`include "fuse_config_loader_params.svh"
module fuse_config_loader (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic cpu_rd_en_in,
	input wire logic cpu_wr_en_in,
	input wire fuse_config_loader_pkg::fuse_addr_t cpu_addr_in,
	input wire fuse_config_loader_pkg::fuse_byte_t cpu_wdata_in,
	output logic [7:0] cpu_rdata_out,
	input wire logic program_debug_port_rd_en_in,
	input wire logic program_debug_port_wr_en_in,
	input wire fuse_config_loader_pkg::fuse_addr_t program_debug_port_addr_in,
	input wire fuse_config_loader_pkg::fuse_byte_t program_debug_port_wdata_in,
	output logic [7:0] program_debug_port_rdata_out,
	output logic [3:0] watchdog_control_first_window_out,
	output logic [3:0] watchdog_control_first_period_out,
	output logic [2:0] brownout_threshold_sel_out,
	output logic brownout_sample_rate_out,
	output logic [1:0] brownout_active_mode_out,
	output logic [1:0] brownout_sleep_mode_out,
	output logic continuous_wait_start_out,
	output logic [3:0] default_clock_source_out,
	output logic config_loaded_out,
	input wire logic brownout_detector_ready_in,
	input wire logic cpu_wake_in,
	output logic cpu_stall_out
);
	import fuse_config_loader_pkg::*;

	typedef struct packed {
		loader_state_t fsm;
		fuse_addr_t load_idx;
		watchdog_ctrl_t wdt;
		logic [2:0] level;
		bod_ctrl_first_t brownout_detector;
		logic [3:0] clk_src;
		logic loaded;
		logic [7:0] cpu_rdata;
		logic [7:0] pdp_rdata;
		logic stall;
		logic [2:0] ready_sync;
		logic wait_mode;
	} loader_reg_t;

	loader_reg_t state_reg;
	loader_reg_t state_next;
	fuse_array_if fuses ();

	function automatic logic is_fuse_addr(input fuse_addr_t a);
		is_fuse_addr = (a <= `FUSE_OFS_BOOT) && !((a >= `FUSE_OFS_RSVD_LO) && (a <= `FUSE_OFS_RSVD_HI));
	endfunction

	fuse_array #(
		.NUM_FUSES(`FUSE_COUNT)
	) u_fuse_array (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.port(fuses)
	);

	// only the programming port reaches the write side; the cpu write strobe goes nowhere
	assign fuses.wr_en = program_debug_port_wr_en_in && is_fuse_addr(program_debug_port_addr_in); // [R1] [R14]
	assign fuses.wr_addr = program_debug_port_addr_in;
	assign fuses.wr_data = program_debug_port_wdata_in;
	// during load the loader owns the read port; otherwise the programmer address takes it ahead of the cpu address
	assign fuses.rd_addr = (state_reg.fsm == ST_LOAD) ? state_reg.load_idx :
		(program_debug_port_rd_en_in ? program_debug_port_addr_in : cpu_addr_in);

	always_comb begin
		state_next = state_reg;
		// detector ready is asynchronous: three flops, agreement of the last two counts
		state_next.ready_sync = {state_reg.ready_sync[1:0], brownout_detector_ready_in};
		unique case (state_reg.fsm)
			ST_RESET: begin
				state_next.fsm = ST_LOAD;
				state_next.load_idx = `FUSE_OFS_WATCHDOG;
			end
			ST_LOAD: begin
				unique case (state_reg.load_idx)
					`FUSE_OFS_WATCHDOG: begin
						state_next.wdt.window = fuses.rd_data[`FUSE_WDT_WINDOW_MSB:`FUSE_WDT_WINDOW_LSB]; // [R5]
						state_next.wdt.period = fuses.rd_data[`FUSE_WDT_PERIOD_MSB:`FUSE_WDT_PERIOD_LSB]; // [R6]
					end
					`FUSE_OFS_BROWNOUT: begin
						state_next.level = fuses.rd_data[`FUSE_BOD_LEVEL_MSB:`FUSE_BOD_LEVEL_LSB]; // [R7]
						state_next.brownout_detector.sample_rate = fuses.rd_data[`FUSE_BOD_SAMP_BIT]; // [R8]
						state_next.brownout_detector.active_mode = bod_mode_t'(fuses.rd_data[`FUSE_BOD_ACT_MSB:`FUSE_BOD_ACT_LSB]); // [R9]
						state_next.brownout_detector.sleep_mode = bod_mode_t'(fuses.rd_data[`FUSE_BOD_SLP_MSB:`FUSE_BOD_SLP_LSB]); // [R11]
					end
					`FUSE_OFS_OSCILLATOR: begin
						state_next.clk_src = fuses.rd_data[`FUSE_OSC_SEL_MSB:`FUSE_OSC_SEL_LSB]; // [R13]
					end
					default: begin
					end
				endcase
				// system, code and boot fuses have targets elsewhere; stop after the oscillator byte
				if (state_reg.load_idx == `FUSE_OFS_OSCILLATOR) begin
					state_next.fsm = ST_RUN;
					state_next.loaded = 1'b1; // [R2]
				end else begin
					state_next.load_idx = state_reg.load_idx + 4'h1;
				end
			end
			ST_RUN: begin
				// control fields are frozen here; only a reset reloads them
				state_next.fsm = ST_RUN; // [R3]
			end
			default: begin
				state_next.fsm = ST_RESET;
			end
		endcase
		// reads: registered, no side effect on the fuse store
		state_next.cpu_rdata = (cpu_rd_en_in && !program_debug_port_rd_en_in && state_reg.fsm == ST_RUN &&
			is_fuse_addr(cpu_addr_in)) ? fuses.rd_data : state_reg.cpu_rdata; // [R14]
		state_next.pdp_rdata = (program_debug_port_rd_en_in && state_reg.fsm == ST_RUN &&
			is_fuse_addr(program_debug_port_addr_in)) ? fuses.rd_data : state_reg.pdp_rdata; // [R1]
		// continuous-with-wait: hold execution at wake until the detector reports running
		if (state_reg.loaded && state_reg.brownout_detector.active_mode == BOD_CONT_WAIT) begin // [R10]
			if (cpu_wake_in) begin
				state_next.stall = 1'b1;
			end
			if (state_reg.stall && state_reg.ready_sync[2] && state_reg.ready_sync[1]) begin
				state_next.stall = 1'b0;
			end
		end else begin
			state_next.stall = 1'b0;
		end
		// cpu held until configuration is in place
		if (!state_reg.loaded) begin
			state_next.stall = 1'b1;
		end else if (state_reg.fsm == ST_RUN && state_reg.loaded && !state_next.loaded) begin
			state_next.stall = 1'b1;
		end
		// registered so the pin comes straight from a flop
		state_next.wait_mode = state_next.loaded && (state_next.brownout_detector.active_mode == BOD_CONT_WAIT); // [R10]
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			state_reg.fsm <= ST_RESET;
			state_reg.load_idx <= 4'h0;
			state_reg.wdt <= 8'h00;
			state_reg.level <= 3'h0;
			state_reg.brownout_detector <= 5'h00;
			state_reg.clk_src <= 4'h0;
			state_reg.loaded <= 1'b0;
			state_reg.cpu_rdata <= 8'h00;
			state_reg.pdp_rdata <= 8'h00;
			state_reg.stall <= 1'b1;
			state_reg.ready_sync <= 3'h0;
			state_reg.wait_mode <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign watchdog_control_first_window_out = state_reg.wdt.window;
	assign watchdog_control_first_period_out = state_reg.wdt.period;
	assign brownout_threshold_sel_out = state_reg.level;
	assign brownout_sample_rate_out = state_reg.brownout_detector.sample_rate;
	assign brownout_active_mode_out = state_reg.brownout_detector.active_mode;
	assign brownout_sleep_mode_out = state_reg.brownout_detector.sleep_mode;
	assign continuous_wait_start_out = state_reg.wait_mode;
	assign default_clock_source_out = state_reg.clk_src;
	assign config_loaded_out = state_reg.loaded;
	assign cpu_stall_out = state_reg.stall;
	assign cpu_rdata_out = state_reg.cpu_rdata;
	assign program_debug_port_rdata_out = state_reg.pdp_rdata;

	a_load_finishes: assert property (@(posedge core_clk_in) disable iff (rst_in)
		$fell(rst_in) |-> ##[1:6] config_loaded_out) else $error("configuration not loaded after reset"); // [R2]
	a_frozen_after_load: assert property (@(posedge core_clk_in) disable iff (rst_in)
		config_loaded_out && $past(config_loaded_out) |-> $stable(watchdog_control_first_window_out) &&
		$stable(brownout_active_mode_out) && $stable(default_clock_source_out))
		else $error("control field changed without reset"); // [R3]
	a_wdt_window_load: assert property (@(posedge core_clk_in) disable iff (rst_in)
		state_reg.fsm == ST_LOAD && state_reg.load_idx == `FUSE_OFS_WATCHDOG |=>
		watchdog_control_first_window_out == $past(fuses.rd_data[7:4])) else $error("window field wrong"); // [R5]
	a_wdt_period_load: assert property (@(posedge core_clk_in) disable iff (rst_in)
		state_reg.fsm == ST_LOAD && state_reg.load_idx == `FUSE_OFS_WATCHDOG |=>
		watchdog_control_first_period_out == $past(fuses.rd_data[3:0])) else $error("period field wrong"); // [R6]
	a_bod_level_load: assert property (@(posedge core_clk_in) disable iff (rst_in)
		state_reg.fsm == ST_LOAD && state_reg.load_idx == `FUSE_OFS_BROWNOUT |=>
		brownout_threshold_sel_out == $past(fuses.rd_data[7:5])) else $error("threshold field wrong"); // [R7]
	a_bod_rate_load: assert property (@(posedge core_clk_in) disable iff (rst_in)
		state_reg.fsm == ST_LOAD && state_reg.load_idx == `FUSE_OFS_BROWNOUT |=>
		brownout_sample_rate_out == $past(fuses.rd_data[4])) else $error("sample rate wrong"); // [R8]
	a_bod_modes_load: assert property (@(posedge core_clk_in) disable iff (rst_in)
		state_reg.fsm == ST_LOAD && state_reg.load_idx == `FUSE_OFS_BROWNOUT |=>
		brownout_active_mode_out == $past(fuses.rd_data[3:2]) && brownout_sleep_mode_out == $past(fuses.rd_data[1:0]))
		else $error("mode fields wrong"); // [R9] [R11]
	a_osc_sel_load: assert property (@(posedge core_clk_in) disable iff (rst_in)
		state_reg.fsm == ST_LOAD && state_reg.load_idx == `FUSE_OFS_OSCILLATOR |=>
		default_clock_source_out == $past(fuses.rd_data[3:0])) else $error("clock source wrong"); // [R13]
	a_wait_stall: assert property (@(posedge core_clk_in) disable iff (rst_in)
		continuous_wait_start_out && cpu_wake_in && !state_reg.stall |=> cpu_stall_out)
		else $error("no stall at wake in wait mode"); // [R10]
	a_cpu_no_write: assert property (@(posedge core_clk_in) disable iff (rst_in)
		cpu_wr_en_in && !program_debug_port_wr_en_in |-> !fuses.wr_en) else $error("cpu write reached fuses"); // [R14]

	// reset behaviour
	a_reset_stall: assert property (@(posedge core_clk_in) // [R2]
		rst_in |=> cpu_stall_out && !config_loaded_out)
		else $error("stall or loaded flag wrong in reset");

	a_reset_ctrl_clear: assert property (@(posedge core_clk_in) // [R2]
		rst_in |=> watchdog_control_first_window_out == 4'h0 && watchdog_control_first_period_out == 4'h0 &&
		brownout_threshold_sel_out == 3'h0 && default_clock_source_out == 4'h0)
		else $error("control fields not cleared in reset");

	a_stall_until_load: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R2]
		!config_loaded_out |-> cpu_stall_out)
		else $error("cpu released before configuration loaded");

	// load sequencing
	a_load_order: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R2]
		state_reg.fsm == ST_LOAD |=> state_reg.fsm == ST_RUN ||
		state_reg.load_idx == $past(state_reg.load_idx) + 4'h1)
		else $error("load index skipped");

	a_load_time: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R2]
		state_reg.fsm == ST_LOAD |-> ##[1:3] config_loaded_out)
		else $error("load sequence too long");

	a_run_stays: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R3]
		state_reg.fsm == ST_RUN |=> state_reg.fsm == ST_RUN)
		else $error("left run state without reset");

	a_rest_frozen: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R3]
		config_loaded_out && $past(config_loaded_out) |-> $stable(watchdog_control_first_period_out) &&
		$stable(brownout_threshold_sel_out) && $stable(brownout_sample_rate_out) && $stable(brownout_sleep_mode_out))
		else $error("control field changed without reset");

	// register port answers
	a_cpu_read_answer: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R14]
		cpu_rd_en_in && !program_debug_port_rd_en_in && config_loaded_out && is_fuse_addr(cpu_addr_in) |=>
		cpu_rdata_out == $past(fuses.rd_data))
		else $error("cpu read data wrong");

	a_pdp_read_answer: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R1]
		program_debug_port_rd_en_in && config_loaded_out && is_fuse_addr(program_debug_port_addr_in) |=>
		program_debug_port_rdata_out == $past(fuses.rd_data))
		else $error("programmer read data wrong");

	a_cpu_read_refused: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R14]
		!cpu_rd_en_in || !is_fuse_addr(cpu_addr_in) |=> $stable(cpu_rdata_out))
		else $error("cpu read data changed without a mapped read");

	a_pdp_read_refused: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R1]
		!program_debug_port_rd_en_in || !is_fuse_addr(program_debug_port_addr_in) |=>
		$stable(program_debug_port_rdata_out))
		else $error("programmer read data changed without a mapped read");

	a_write_only_pdp: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R1]
		fuses.wr_en |-> program_debug_port_wr_en_in && is_fuse_addr(program_debug_port_addr_in))
		else $error("fuse write without programmer strobe");

	// wake stall in continuous-with-wait mode
	a_wait_flag: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R10]
		continuous_wait_start_out == (config_loaded_out && brownout_active_mode_out == 2'h3))
		else $error("wait flag disagrees with active mode");

	a_no_stall_other: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R10]
		config_loaded_out && $past(config_loaded_out) && brownout_active_mode_out != 2'h3 |-> !cpu_stall_out)
		else $error("stall outside wait mode");

	a_stall_hold: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R10]
		continuous_wait_start_out && cpu_stall_out && !state_reg.ready_sync[2] |=> cpu_stall_out)
		else $error("stall dropped before detector ready");

	a_stall_release: assert property (@(posedge core_clk_in) disable iff (rst_in) // [R10]
		config_loaded_out && cpu_stall_out && state_reg.ready_sync[2] && state_reg.ready_sync[1] |=>
		!cpu_stall_out)
		else $error("stall kept after detector ready");
endmodule

/* sim/fuse_programmer_model.sv */
// programming and debug port model driving fuse reads and writes
`timescale 1ns/1ps
`include "fuse_config_loader_params.svh"
module fuse_programmer_model (
	input wire logic core_clk_in,
	input wire logic [7:0] rdata_in,
	output logic rd_en_out,
	output logic wr_en_out,
	output logic [3:0] addr_out,
	output logic [7:0] wdata_out
);
	initial begin
		rd_en_out = 1'b0;
		wr_en_out = 1'b0;
		addr_out = 4'h0;
		wdata_out = 8'h00;
	end
	// only this port may change a fuse
	task automatic write_byte(input logic [3:0] addr, input logic [7:0] data);
		@(posedge core_clk_in);
		wr_en_out <= 1'b1;
		addr_out <= addr;
		wdata_out <= (addr == `FUSE_OFS_OSCILLATOR) ? (data & ~`FUSE_OSC_RSVD_MASK) : data;
		@(posedge core_clk_in);
		wr_en_out <= 1'b0;
		wdata_out <= ~data;
	endtask
	task automatic read_byte(input logic [3:0] addr, output logic [7:0] data);
		@(posedge core_clk_in);
		rd_en_out <= 1'b1;
		addr_out <= addr;
		@(posedge core_clk_in);
		rd_en_out <= 1'b0;
		@(negedge core_clk_in);
		data = rdata_in;
	endtask
endmodule

/* sim/tb_fuse_config_loader.sv */
// self-checking bench for the fuse loader
`timescale 1ns/1ps
`include "fuse_config_loader_params.svh"
module tb_fuse_config_loader;
	import fuse_config_loader_pkg::*;
	typedef struct {
		logic [7:0] wdt, brownout_detector, osc;
		logic [3:0] win, per;
		logic [2:0] lvl;
		logic samp;
		logic [1:0] act, slp;
		logic [3:0] clk;
	} row_t;
	logic core_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic cpu_rd_en_in = 1'b0, cpu_wr_en_in = 1'b0, cpu_wake_in = 1'b0, brownout_detector_ready_in = 1'b1;
	fuse_addr_t cpu_addr_in = 4'h0, program_debug_port_addr_in;
	fuse_byte_t cpu_wdata_in = 8'h00, program_debug_port_wdata_in;
	logic program_debug_port_rd_en_in, program_debug_port_wr_en_in, continuous_wait_start_out;
	logic [7:0] cpu_rdata_out, program_debug_port_rdata_out, d;
	logic [3:0] watchdog_control_first_window_out, watchdog_control_first_period_out, default_clock_source_out;
	logic [2:0] brownout_threshold_sel_out;
	logic [1:0] brownout_active_mode_out, brownout_sleep_mode_out;
	logic brownout_sample_rate_out, config_loaded_out, cpu_stall_out;
	int num_errors = 0;
	int n_tests = 0;
	row_t rows [5];
	always #2.5 core_clk_in = ~core_clk_in;
	fuse_config_loader DUT (.*);
	fuse_programmer_model prog (.core_clk_in(core_clk_in), .rdata_in(program_debug_port_rdata_out),
		.rd_en_out(program_debug_port_rd_en_in), .wr_en_out(program_debug_port_wr_en_in),
		.addr_out(program_debug_port_addr_in), .wdata_out(program_debug_port_wdata_in));
	task automatic conclude();
		if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cpu_read(input logic [3:0] a, output logic [7:0] v);
		@(posedge core_clk_in);
		cpu_rd_en_in <= 1'b1;
		cpu_addr_in <= a;
		@(posedge core_clk_in);
		cpu_rd_en_in <= 1'b0;
		@(negedge core_clk_in);
		v = cpu_rdata_out;
	endtask
	// fuses survive reset, so only the control copies are reloaded
	task automatic do_reset(input int cycles);
		int k;
		@(posedge core_clk_in);
		rst_in <= 1'b1;
		repeat (cycles) @(posedge core_clk_in);
		rst_in <= 1'b0;
		k = 0;
		while (config_loaded_out !== 1'b1 && k < 20) begin
			@(posedge core_clk_in);
			k++;
		end
		@(negedge core_clk_in);
		chk({7'h0, config_loaded_out}, 8'h01);
	endtask
	task automatic chk_ctrl(input row_t r);
		chk({4'h0, watchdog_control_first_window_out}, {4'h0, r.win});
		chk({4'h0, watchdog_control_first_period_out}, {4'h0, r.per});
		chk({5'h0, brownout_threshold_sel_out}, {5'h0, r.lvl});
		chk({7'h0, brownout_sample_rate_out}, {7'h0, r.samp});
		chk({6'h0, brownout_active_mode_out}, {6'h0, r.act});
		chk({6'h0, brownout_sleep_mode_out}, {6'h0, r.slp});
		chk({7'h0, continuous_wait_start_out}, {7'h0, r.act == 2'h3});
		chk({4'h0, default_clock_source_out}, {4'h0, r.clk});
	endtask
	// ready is synchronised, so the stall outlives a low ready by a few cycles
	task automatic wake_test(input logic exp);
		int k;
		@(posedge core_clk_in);
		brownout_detector_ready_in <= ~exp;
		repeat (5) @(posedge core_clk_in);
		cpu_wake_in <= 1'b1;
		@(posedge core_clk_in);
		cpu_wake_in <= 1'b0;
		repeat (3) @(posedge core_clk_in);
		@(negedge core_clk_in);
		chk({7'h0, cpu_stall_out}, {7'h0, exp});
		brownout_detector_ready_in <= 1'b1;
		k = 0;
		while (cpu_stall_out !== 1'b0 && k < 10) begin
			@(negedge core_clk_in);
			k++;
		end
		chk({7'h0, cpu_stall_out}, 8'h00);
	endtask
	initial begin
		rows[0] = '{8'h00, 8'h00, 8'h00, 4'h0, 4'h0, 3'h0, 1'b0, 2'h0, 2'h0, 4'h0};
		rows[1] = '{8'h5a, 8'h16, 8'h01, 4'h5, 4'ha, 3'h0, 1'b1, 2'h1, 2'h2, 4'h1};
		rows[2] = '{8'hf0, 8'h69, 8'h00, 4'hf, 4'h0, 3'h3, 1'b0, 2'h2, 2'h1, 4'h0};
		rows[3] = '{8'h0f, 8'h2c, 8'h01, 4'h0, 4'hf, 3'h1, 1'b0, 2'h3, 2'h0, 4'h1};
		rows[4] = '{8'h3c, 8'h52, 8'h00, 4'h3, 4'hc, 3'h2, 1'b1, 2'h0, 2'h2, 4'h0};
		do_reset(8);
		for (int i = 0; i < 5; i++) begin
			if (i > 0) begin
				prog.write_byte(`FUSE_OFS_WATCHDOG, rows[i].wdt);
				prog.write_byte(`FUSE_OFS_BROWNOUT, rows[i].brownout_detector);
				prog.write_byte(`FUSE_OFS_OSCILLATOR, rows[i].osc);
				repeat (2) @(posedge core_clk_in);
				@(negedge core_clk_in);
				chk_ctrl(rows[i - 1]);
				do_reset(2);
			end
			chk_ctrl(rows[i]);
			cpu_read(`FUSE_OFS_WATCHDOG, d);
			chk(d, rows[i].wdt);
			cpu_read(`FUSE_OFS_BROWNOUT, d);
			chk(d, rows[i].brownout_detector);
			cpu_read(`FUSE_OFS_OSCILLATOR, d);
			chk(d, rows[i].osc);
			if (i > 0) wake_test(rows[i].act == 2'h3);
		end
		@(posedge core_clk_in);
		cpu_wr_en_in <= 1'b1;
		cpu_addr_in <= `FUSE_OFS_WATCHDOG;
		cpu_wdata_in <= 8'hff;
		@(posedge core_clk_in);
		cpu_wr_en_in <= 1'b0;
		cpu_read(`FUSE_OFS_WATCHDOG, d);
		chk(d, rows[4].wdt);
		cpu_read(`FUSE_OFS_RSVD_LO, d);
		chk(d, rows[4].wdt);
		prog.read_byte(`FUSE_OFS_BROWNOUT, d);
		chk(d, rows[4].brownout_detector);
		prog.write_byte(`FUSE_OFS_SYSTEM_CONFIG_FUSE_0, 8'h59);
		cpu_read(`FUSE_OFS_SYSTEM_CONFIG_FUSE_0, d);
		chk(d, 8'h59);
		conclude();
	end
	initial begin
		#10000;
		num_errors++;
		conclude();
	end
endmodule
